// ### verilog/general_purpose_event_logic.sv
// What this block does
// R1 - software power change sets bit 7
// R2 - 12 V request change sets bit 6
// R3 - input level change sets bits 4..0
// R4 - only global reset clears status, enable
// R5 - bit 5 reads zero, ignores writes
// R6 - enabled pending flag signals event output
// R7 - input register shows live levels 4..0
// R8 - input bits 7..5 zero, writes discarded
// R9 - write one clears flag, event wins
// R10 - event output active low level
`timescale 1ns/100ps
`default_nettype none
`include "gp_event_consts.svh"

module general_purpose_event_logic
  import gp_event_pkg::*;
#(
  parameter int INPUT_COUNT = 5
) (
  // clock, global reset, clock enable
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  // configuration byte access
  input wire cfg_req_t cfgReq,
  output cfg_rsp_t cfgRsp,
  // multipurpose terminals, sampled as synchronous inputs
  input wire logic multipurposeTerminal5,
  input wire logic multipurposeTerminal4,
  input wire logic multipurposeTerminal2,
  input wire logic multipurposeTerminal1,
  input wire logic multipurposeTerminal0,
  // which flag bits 4..0 have their terminal routed as an input
  input wire logic [4:0] terminalIsInput,
  // socket power side: software write pulse and 12 V request level
  input wire logic socketPowerWrite,
  input wire logic vppRequest12V,
  // system event output
  output logic systemEventOut_n
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration check: flag layout is fixed at five inputs
  generate
    if (INPUT_COUNT != 5) begin : g_bad_count
      $error("general_purpose_event_logic: only five inputs are served");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // input terminals
  logic [4:0] terminalPins; // packed in flag-bit order
  logic [4:0] levelNow; // registered levels
  logic [4:0] inChange; // change pulses, already gated by clkEn

  // bit 4 is terminal 5, bit 3 terminal 4, then 2, 1, 0
  assign terminalPins = {multipurposeTerminal5, multipurposeTerminal4, multipurposeTerminal2,
                         multipurposeTerminal1, multipurposeTerminal0};

  gp_input_watch #(
    .WIDTH(INPUT_COUNT)
  ) u_watch (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .pins(terminalPins),
    .isInput(terminalIsInput),
    .level(levelNow),
    .change(inChange)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 12 V request edge detect
  logic vppPrev_q; // last request level
  logic vppPrev_d;
  logic vppPrimed_q; // avoids a false edge right after reset
  logic vppPrimed_d;
  logic vppChange; // request moved into or out of 12 V

  // next values
  always_comb begin
    vppPrev_d = vppPrev_q;
    vppPrimed_d = vppPrimed_q;
    if (clkEn) begin
      vppPrev_d = vppRequest12V;
      vppPrimed_d = 1'b1;
    end
  end

  // registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      vppPrev_q <= 1'b0;
      vppPrimed_q <= 1'b0;
    end else begin
      vppPrev_q <= vppPrev_d;
      vppPrimed_q <= vppPrimed_d;
    end
  end

  // R2 into or out of 12 V
  assign vppChange = clkEn & vppPrimed_q & (vppRequest12V ^ vppPrev_q);

  ////////////////////////////////////////////////////////////////////////////
  // status, enable and read answer
  cfg_byte_t status_q; // sticky event flags
  cfg_byte_t status_d;
  cfg_byte_t enable_q; // per-flag event enables
  cfg_byte_t enable_d;
  cfg_rsp_t rsp_q; // registered read answer
  cfg_rsp_t rsp_d;
  logic eventN_q; // event output, low while an enabled flag is pending
  logic eventN_d;
  cfg_byte_t events; // this cycle's hardware set requests
  logic wrStatus; // write strobe hits status
  logic wrEnable; // write strobe hits enable

  assign wrStatus = clkEn & cfgReq.wr & (cfgReq.addr == `EVT_STATUS_OFS);
  assign wrEnable = clkEn & cfgReq.wr & (cfgReq.addr == `EVT_ENABLE_OFS);

  // R1 software power change
  assign events = {clkEn & socketPowerWrite, vppChange, 1'b0, inChange};

  // next values; a write to the input register matches nothing that stores
  always_comb begin
    status_d = status_q;
    enable_d = enable_q;
    rsp_d = '0;
    // R9 write one clears
    if (wrStatus) begin
      status_d = status_q & ~cfgReq.wdata;
    end
    // R9 set wins clear, so an event in the clear cycle survives
    status_d = status_d | events;
    // R5 reserved bit held
    status_d = status_d & `EVT_WRITE_MASK;
    if (wrEnable) begin
      enable_d = cfgReq.wdata & `EVT_WRITE_MASK;
    end
    // a stopped clock enable holds the read answer as well, so no state moves while it is low
    if (!clkEn) begin
      rsp_d = rsp_q;
    end
    // reads return the value before any same-cycle write
    if (clkEn && cfgReq.rd) begin
      rsp_d.valid = 1'b1;
      if (cfgReq.addr == `EVT_STATUS_OFS) begin
        rsp_d.data = status_q;
      end else if (cfgReq.addr == `EVT_ENABLE_OFS) begin
        rsp_d.data = enable_q;
      end else if (cfgReq.addr == `INPUT_LEVELS_OFS) begin
        // R7 R8 live levels, upper zero
        rsp_d.data = {3'h0, levelNow} & `INPUT_READ_MASK;
      end else begin
        // bytes outside this block answer zero
        rsp_d.data = `UNMAPPED_READ;
      end
    end
    // R6 R10 enabled flag drives low
    eventN_d = ~|(status_d & enable_d);
  end

  // R4 only global reset clears
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= `EVT_STATUS_RESET;
      enable_q <= `EVT_ENABLE_RESET;
      rsp_q <= '0;
      eventN_q <= 1'b1;
    end else begin
      status_q <= status_d;
      enable_q <= enable_d;
      rsp_q <= rsp_d;
      eventN_q <= eventN_d;
    end
  end

  assign cfgRsp = rsp_q;
  assign systemEventOut_n = eventN_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  property p_power_sets;
    (clkEn && socketPowerWrite) |=> status_q[`POWER_FLAG_BIT];
  endproperty
  a_power_sets: assert property (p_power_sets) else $error("power flag not set"); // R1

  property p_vpp_sets;
    (clkEn && vppPrimed_q && (vppRequest12V != vppPrev_q)) |=> status_q[`HIGH_PROG_FLAG_BIT];
  endproperty
  a_vpp_sets: assert property (p_vpp_sets) else $error("12 V flag not set"); // R2

  property p_input_sets;
    (|inChange) |=> ((status_q[4:0] & $past(inChange)) == $past(inChange));
  endproperty
  a_input_sets: assert property (p_input_sets) else $error("input flag not set"); // R3

  property p_status_holds;
    (!wrStatus && events == 8'h00) |=> $stable(status_q);
  endproperty
  a_status_holds: assert property (p_status_holds) else $error("status moved without cause"); // R4

  property p_enable_holds;
    !wrEnable |=> $stable(enable_q);
  endproperty
  a_enable_holds: assert property (p_enable_holds) else $error("enable moved without write"); // R4

  property p_rsvd_zero;
    (wrStatus || wrEnable) |=> (!status_q[`RSVD_FLAG_BIT] && !enable_q[`RSVD_FLAG_BIT]);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set"); // R5

  property p_event_out;
    systemEventOut_n == !(|(status_q & enable_q));
  endproperty
  a_event_out: assert property (p_event_out) else $error("event output wrong"); // R6

  property p_event_level;
    (!systemEventOut_n && !wrStatus && !wrEnable) |=> !systemEventOut_n;
  endproperty
  a_event_level: assert property (p_event_level) else $error("event output dropped"); // R10

  property p_input_read;
    (clkEn && cfgReq.rd && cfgReq.addr == `INPUT_LEVELS_OFS) |=>
      (cfgRsp.valid && cfgRsp.data == {3'h0, $past(levelNow)});
  endproperty
  a_input_read: assert property (p_input_read) else $error("input read wrong"); // R7

  property p_input_write;
    (clkEn && cfgReq.wr && cfgReq.addr == `INPUT_LEVELS_OFS && events == 8'h00) |=>
      ($stable(status_q) && $stable(enable_q));
  endproperty
  a_input_write: assert property (p_input_write) else $error("input write stored"); // R8

  property p_clear;
    wrStatus |=> ((status_q & $past(cfgReq.wdata) & ~$past(events)) == 8'h00);
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared"); // R9

  cover property (wrStatus && (|events));
  cover property ($fell(systemEventOut_n));
  cover property ($rose(systemEventOut_n) && $past(wrStatus));
  cover property (|inChange);

endmodule : general_purpose_event_logic

`default_nettype wire

// ### verilog/gp_event_consts.svh
`ifndef GP_EVENT_CONSTS_SVH
`define GP_EVENT_CONSTS_SVH

// configuration byte offsets
`define EVT_STATUS_OFS 8'h88
`define EVT_ENABLE_OFS 8'h89
`define INPUT_LEVELS_OFS 8'h8a

// field positions inside the status and enable bytes
`define POWER_FLAG_BIT 7
`define HIGH_PROG_FLAG_BIT 6
`define RSVD_FLAG_BIT 5
`define INPUT_FLAG_TOP 4

// reset values
`define EVT_STATUS_RESET 8'h00
`define EVT_ENABLE_RESET 8'h00
`define INPUT_LEVELS_RESET 5'h00

// writable bits of status and enable, readable bits of input levels
`define EVT_WRITE_MASK 8'hdf
`define INPUT_READ_MASK 8'h1f

// answer for a byte this block does not decode
`define UNMAPPED_READ 8'h00

`endif

// ### verilog/gp_event_pkg.sv
package gp_event_pkg;

  // one configuration byte
  typedef logic [7:0] cfg_byte_t;

  // byte request from the configuration space decoder
  typedef struct packed {
    logic rd;
    logic wr;
    cfg_byte_t addr;
    cfg_byte_t wdata;
  } cfg_req_t;

  // read answer, valid one cycle after the read strobe
  typedef struct packed {
    logic valid;
    cfg_byte_t data;
  } cfg_rsp_t;

endpackage : gp_event_pkg

// ### verilog/gp_input_watch.sv
`timescale 1ns/100ps
`default_nettype none

module gp_input_watch #(
  parameter int WIDTH = 5
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  // terminal levels and their routing
  input wire logic [WIDTH-1:0] pins,
  input wire logic [WIDTH-1:0] isInput,
  // registered level and change pulse
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] change
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration check
  generate
    if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
      $error("gp_input_watch: width must be 1 to 8");
    end
  endgenerate

  logic [WIDTH-1:0] level_q; // last sampled pin levels
  logic [WIDTH-1:0] level_d;
  logic primed_q; // first sample taken since reset
  logic primed_d;

  ////////////////////////////////////////////////////////////////////////////
  // next values: sample every enabled cycle
  always_comb begin
    level_d = level_q;
    primed_d = primed_q;
    if (clkEn) begin
      level_d = pins;
      primed_d = 1'b1;
    end
  end

  // registers; primed_q stays low until the first sample, so the first sample is not a change
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      level_q <= '0;
      primed_q <= 1'b0;
    end else begin
      level_q <= level_d;
      primed_q <= primed_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-bit change: only terminals routed as inputs count
  genvar k;
  generate
    for (k = 0; k < WIDTH; k++) begin : g_bit
      // R3 level change detect
      assign change[k] = clkEn & primed_q & isInput[k] & (pins[k] ^ level_q[k]);
    end
  endgenerate

  assign level = level_q;

endmodule : gp_input_watch

`default_nettype wire

// ### dv/board_model.sv
`timescale 1ns/100ps
`default_nettype none

// board side of the block: five input terminals, the socket power software strobe and the 12 V request level
module board_model (
  // commands from the bench
  input wire logic [4:0] levelCmd,
  input wire logic powerCmd,
  input wire logic vppCmd,
  // terminal levels toward the block
  output logic term5,
  output logic term4,
  output logic term2,
  output logic term1,
  output logic term0,
  // power side toward the block
  output logic powerWrite,
  output logic vpp12
);
  ////////////////////////////////////////////////////////////////
  // pins are plain driven levels, no pull, so no idle value to fake
  // terminal bit order
  assign {term5, term4, term2, term1, term0} = levelCmd;
  // power strobe is one cycle wide, the bench keeps it so
  assign powerWrite = powerCmd;
  assign vpp12 = vppCmd;
endmodule : board_model

`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "gp_event_consts.svh"

module tb_top
  import gp_event_pkg::*;
;
  // bench stimulus and design outputs
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clkEn = 1'b1;
  cfg_req_t cfgReq = '0;
  cfg_rsp_t cfgRsp;
  logic [4:0] levelCmd = 5'h00;
  logic [4:0] isIn = 5'h1f;
  logic powerCmd = 1'b0;
  logic vppCmd = 1'b0;
  logic t5, t4, t2, t1, t0, pw, vpp, evtN;
  int n_mismatch = 0;
  int n_compared = 0;
  // expected read bytes, oldest first
  cfg_byte_t expQ[$];

  board_model i_board (.levelCmd(levelCmd), .powerCmd(powerCmd), .vppCmd(vppCmd), .term5(t5), .term4(t4),
    .term2(t2), .term1(t1), .term0(t0), .powerWrite(pw), .vpp12(vpp));
  general_purpose_event_logic #(.INPUT_COUNT(5)) i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .clkEn(clkEn),
    .cfgReq(cfgReq), .cfgRsp(cfgRsp), .multipurposeTerminal5(t5), .multipurposeTerminal4(t4),
    .multipurposeTerminal2(t2), .multipurposeTerminal1(t1), .multipurposeTerminal0(t0),
    .terminalIsInput(isIn), .socketPowerWrite(pw), .vppRequest12V(vpp), .systemEventOut_n(evtN));

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  // one byte write; the extra edge lets its effect land
  task automatic wr(input cfg_byte_t a, input cfg_byte_t d);
    cfgReq.wr <= 1'b1;
    cfgReq.addr <= a;
    cfgReq.wdata <= d;
    @(posedge sys_clk);
    cfgReq.wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  // one byte read; the answer is judged by the monitor
  task automatic rd(input cfg_byte_t a, input cfg_byte_t e);
    expQ.push_back(e);
    cfgReq.rd <= 1'b1;
    cfgReq.addr <= a;
    @(posedge sys_clk);
    cfgReq.rd <= 1'b0;
    @(posedge sys_clk);
  endtask : rd

  task automatic cmpByte(input cfg_byte_t e, input cfg_byte_t g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected read data expected %h seen %h", e, g);
    end
  endtask : cmpByte

  // event output looked at mid-cycle, where it has settled
  task automatic chkEvt(input logic e);
    @(negedge sys_clk);
    n_compared++;
    if (evtN !== e) begin
      n_mismatch++;
      $display("unexpected event output expected %b seen %b", e, evtN);
    end
    @(posedge sys_clk);
  endtask : chkEvt

  task automatic summarize();
    // a read answer that never came is a mismatch too
    if (expQ.size() != 0) n_mismatch++;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////
  // monitor: each valid answer takes the oldest note
  always @(negedge sys_clk) begin
    if (cfgRsp.valid === 1'b1) begin
      if (expQ.size() == 0) cmpByte(8'h00, 8'hff);
      else cmpByte(expQ.pop_front(), cfgRsp.data);
    end
  end

  // watchdog, 5000 cycles, far beyond the roughly 130 cycles the run needs
  initial begin
    #100000;
    n_mismatch++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] rnd;
    void'($urandom(65));
    cyc(10);
    reset_n <= 1'b1;
    // detectors take their first sample first
    cyc(3);
    rd(`EVT_STATUS_OFS, `EVT_STATUS_RESET);
    rd(`EVT_ENABLE_OFS, `EVT_ENABLE_RESET);
    chkEvt(1'b1);
    wr(`EVT_ENABLE_OFS, 8'hff);
    rd(`EVT_ENABLE_OFS, `EVT_WRITE_MASK);
    wr(`EVT_STATUS_OFS, 8'h20);
    rd(`EVT_STATUS_OFS, 8'h00);
    // every terminal in turn: flag, output, clear
    for (int k = 0; k < 5; k++) begin
      levelCmd[k] <= ~levelCmd[k];
      cyc(2);
      rd(`EVT_STATUS_OFS, 8'h01 << k);
      chkEvt(1'b0);
      wr(`EVT_STATUS_OFS, 8'h01 << k);
      rd(`EVT_STATUS_OFS, 8'h00);
      chkEvt(1'b1);
    end
    // power strobe and entering 12 V
    powerCmd <= 1'b1;
    cyc(1);
    powerCmd <= 1'b0;
    vppCmd <= 1'b1;
    cyc(2);
    rd(`EVT_STATUS_OFS, 8'hc0);
    wr(`EVT_ENABLE_OFS, 8'h40);
    wr(`EVT_STATUS_OFS, 8'h40);
    chkEvt(1'b1);
    rd(`EVT_STATUS_OFS, 8'h80);
    // leaving 12 V counts as a change too
    vppCmd <= 1'b0;
    cyc(2);
    chkEvt(1'b0);
    wr(`EVT_STATUS_OFS, 8'hc0);
    // a change landing with its own clear keeps the flag
    levelCmd[0] <= ~levelCmd[0];
    cyc(2);
    levelCmd[0] <= ~levelCmd[0];
    wr(`EVT_STATUS_OFS, 8'h01);
    rd(`EVT_STATUS_OFS, 8'h01);
    // only routed inputs raise a flag
    rnd = $urandom;
    isIn <= rnd[4:0];
    levelCmd <= ~levelCmd;
    cyc(2);
    rd(`EVT_STATUS_OFS, {3'b000, rnd[4:0]} | 8'h01);
    isIn <= 5'h1f;
    rnd = $urandom;
    levelCmd <= rnd[4:0];
    cyc(2);
    rd(`INPUT_LEVELS_OFS, {3'b000, rnd[4:0]});
    wr(`INPUT_LEVELS_OFS, 8'hff);
    rd(`INPUT_LEVELS_OFS, {3'b000, rnd[4:0]});
    rd(8'h8b, `UNMAPPED_READ);
    // a write with the clock enable low is dropped
    clkEn <= 1'b0;
    wr(`EVT_ENABLE_OFS, 8'h00);
    clkEn <= 1'b1;
    rd(`EVT_ENABLE_OFS, 8'h40);
    // only the global reset wipes pending state
    wr(`EVT_ENABLE_OFS, 8'h80);
    powerCmd <= 1'b1;
    cyc(1);
    powerCmd <= 1'b0;
    chkEvt(1'b0);
    reset_n <= 1'b0;
    cyc(2);
    reset_n <= 1'b1;
    cyc(3);
    rd(`EVT_STATUS_OFS, 8'h00);
    rd(`EVT_ENABLE_OFS, 8'h00);
    chkEvt(1'b1);
    summarize();
  end
endmodule : tb_top

`default_nettype wire
